// ===== shared/ufc_defines.svh
/*
  register indices, field positions, reset values and timing counts for the
  in-band flow control, interrupt priority, time-out and baud generator block.
  assumes apb byte address = 4 * register index.
*/
// Function
// - with flow control on, compare one or two received characters to resume/suspend values.
// - on suspend match, stop transmitting after the current character completes.
// - suspend match sets its flag if enabled and may raise the interrupt.
// - while suspended, a resume match restarts transmission and clears the flag.
// - reset clears all four flow character registers to zero.
// - double mode needs two consecutive characters matching first then second value.
// - matched flow characters never enter the receive fifo, except the special character in special mode.
// - auto send transmits suspend characters when received count passes trigger.
// - after suspend was sent, send resume characters when count falls below trigger.
// - special mode matches second suspend character, stores it, sets special flag.
// - comparisons use only the word-length bits, bit 0 first received.
// - each interrupt source gated by its enable bit.
// - enabling the transmit-holding interrupt after reset raises it at once.
// - status shows only the highest pending source; pin flow lowest.
// - data-ready and time-out share one level and enable; data fires at trigger.
// - no time-out while the receive fifo is empty.
// - time-out counter restarts at each stop-bit middle and each holding read.
// - time-out is four character times including start, parity and stop length.
// - one generator divides the clock by a divisor 1 to 65535 to give the 16x tick.
// - bit rate is clock over 16 over divisor; sixteen ticks per bit.
// - divisor high byte gives bits 15..8, low byte bits 7..0.
// - flow character and feature registers reachable only when line format is bf.
// - divisor bytes replace data and mask registers while line format bit 7 set.
`ifndef UFC_DEFINES_SVH
`define UFC_DEFINES_SVH
`define UFC_IDX_DATA    3'h0
`define UFC_IDX_MASK    3'h1
`define UFC_IDX_SRC     3'h2
`define UFC_IDX_FMT     3'h3
`define UFC_IDX_RES1    3'h4
`define UFC_IDX_RES2    3'h5
`define UFC_IDX_SUS1    3'h6
`define UFC_IDX_SUS2    3'h7
`define UFC_FMT_DIVSEL  7
`define UFC_FMT_ENH     8'hbf
`define UFC_RST_BYTE    8'h00
`define UFC_MASK_RXD    0
`define UFC_MASK_THR    1
`define UFC_MASK_LINE   2
`define UFC_MASK_MSR    3
`define UFC_MASK_SUSP   5
`define UFC_FEAT_SPEC   5
`define UFC_SRC_NONE    6'h01
`define UFC_SRC_LINE    6'h06
`define UFC_SRC_RXD     6'h04
`define UFC_SRC_RXTO    6'h0c
`define UFC_SRC_THR     6'h02
`define UFC_SRC_MSR     6'h00
`define UFC_SRC_SUSP    6'h10
`define UFC_SRC_PIN     6'h20
`define UFC_TICKS_BIT   10'd16
`define UFC_TO_CHARS    10'd4
`endif

// ===== shared/ufc_pkg.sv
/*
  types for the flow control / interrupt / baud block.
  assumes nothing beyond a systemverilog tool.
*/
package ufc_pkg;
  typedef enum logic [1:0] {RX_IDLE = 2'b01, RX_HELD = 2'b10} ufc_rx_t;
  typedef enum logic [2:0] {SN_IDLE = 3'b001, SN_FIRST = 3'b010, SN_SECOND = 3'b100} ufc_send_t;
  typedef struct packed {
    logic [7:0]  fmt;
    logic [7:0]  mask;
    logic [7:0]  feat;
    logic [7:0]  res1;
    logic [7:0]  res2;
    logic [7:0]  sus1;
    logic [7:0]  sus2;
    logic [7:0]  divLow;
    logic [7:0]  divHigh;
    logic [15:0] baudCnt;
    logic        baudTick;
    logic [9:0]  toCnt;
    logic        toFlag;
    ufc_rx_t     rxSt;
    logic [7:0]  heldChar;
    logic        heldSus;
    logic        deferValid;
    logic [7:0]  deferChar;
    logic        txSuspended;
    logic        txStartOk;
    logic        susFlag;
    logic        specialFlag;
    ufc_send_t   sendSt;
    logic        sendSus;
    logic        sentSus;
    logic        thrPend;
    logic        prevThrEmpty;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        rxPush;
    logic [7:0]  rxPushData;
    logic        holdRead;
    logic        thrWrite;
    logic [7:0]  thrData;
    logic        injValid;
    logic [7:0]  injChar;
    logic        irq;
  } ufc_state_t;
endpackage

// ===== rtl/ufc_flow_ctrl.sv
/*
  flow control characters, interrupt priority, receive time-out and baud
  generator of one serial channel, with an apb register slave.
  assumes the channel's fifo, shifters and line logic sit outside and are
  synchronous to clock; received characters arrive at least two cycles apart.
*/
// Decided for this implementation: the address map and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "ufc_defines.svh"
module ufc_flow_ctrl #(
  parameter int ADDR_W = 5
) (
  // clock and reset
  input  wire logic              clock,
  input  wire logic              rst,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // receive side of the channel
  input  wire logic              rxCharValid,
  input  wire logic [7:0]        rxChar,
  input  wire logic              rxStopMid,
  input  wire logic [5:0]        rxFifoCount,
  input  wire logic [7:0]        rxFifoData,
  input  wire logic [5:0]        rxTrigLevel,
  input  wire logic              fifoEnabled,
  output logic                   rxPush,
  output logic      [7:0]        rxPushData,
  output logic                   holdRead,
  // transmit side of the channel
  input  wire logic              thrEmpty,
  input  wire logic              injTaken,
  output logic                   thrWrite,
  output logic      [7:0]        thrData,
  output logic                   txStartOk,
  output logic                   injValid,
  output logic      [7:0]        injChar,
  // other interrupt sources
  input  wire logic              lineStatusErr,
  input  wire logic              modemStatusChg,
  input  wire logic              pinFlowEvent,
  // results
  output logic                   baudTick,
  output logic                   irq
);
  ufc_pkg::ufc_state_t s;
  ufc_pkg::ufc_state_t n;

  logic       setup;
  logic       acc;
  logic       enh;
  logic       dlab;
  logic [2:0] idx;
  logic       mapped;
  logic [5:0] srcCode;
  logic [7:0] rdVal;
  logic       cmpOn;
  logic       cmpDbl;
  logic [7:0] offC;
  logic [7:0] onC;
  logic       autoOn;
  logic       autoDbl;
  logic [9:0] toLimit;
  logic       srcRead;
  logic       divWr;

  function automatic logic chEq(input logic [7:0] a, input logic [7:0] b,
                                input logic [1:0] wl);
    logic [7:0] m;
    m = 8'hff >> (3'h3 - {1'b0, wl});
    return ((a ^ b) & m) == 8'h00;
  endfunction

  function automatic logic [9:0] charTicks(input logic [7:0] f);
    logic [9:0] bits;
    logic [9:0] stop;
    bits = 10'd6 + {8'h00, f[1:0]} + {9'h000, f[3]};
    if (!f[2])
      stop = `UFC_TICKS_BIT;
    else if (f[1:0] == 2'b00)
      stop = 10'd24;
    else
      stop = 10'd32;
    return bits * `UFC_TICKS_BIT + stop;
  endfunction

  always_comb begin
    enh = s.fmt == `UFC_FMT_ENH;
    dlab = s.fmt[`UFC_FMT_DIVSEL];
    idx = paddr[4:2];
    setup = psel && !penable;
    acc = psel && penable && s.pready;
    // register map: format byte bf opens the flow set, divisor bit opens divisor bytes
    case (idx)
      `UFC_IDX_DATA, `UFC_IDX_MASK, `UFC_IDX_FMT: mapped = 1'b1;
      `UFC_IDX_SRC: mapped = enh || !pwrite;
      default: mapped = enh;
    endcase
    mapped = mapped && (paddr[1:0] == 2'b00);
    // single highest source; pin flow events only when nothing else pends
    if (s.mask[`UFC_MASK_LINE] && lineStatusErr)
      srcCode = `UFC_SRC_LINE;
    else if (s.mask[`UFC_MASK_RXD] && rxFifoCount != 6'h00 && rxFifoCount >= rxTrigLevel)
      srcCode = `UFC_SRC_RXD;
    else if (s.mask[`UFC_MASK_RXD] && s.toFlag)
      srcCode = `UFC_SRC_RXTO;
    else if (s.mask[`UFC_MASK_THR] && s.thrPend)
      srcCode = `UFC_SRC_THR;
    else if (s.mask[`UFC_MASK_MSR] && modemStatusChg)
      srcCode = `UFC_SRC_MSR;
    else if (s.mask[`UFC_MASK_SUSP] && (s.susFlag || s.specialFlag))
      srcCode = `UFC_SRC_SUSP;
    else if ((s.mask[7] || s.mask[6]) && pinFlowEvent)
      srcCode = `UFC_SRC_PIN;
    else
      srcCode = `UFC_SRC_NONE;
    case (idx)
      `UFC_IDX_DATA: rdVal = dlab ? s.divLow : rxFifoData;
      `UFC_IDX_MASK: rdVal = dlab ? s.divHigh : s.mask;
      `UFC_IDX_SRC: rdVal = enh ? s.feat : {fifoEnabled, fifoEnabled, srcCode};
      `UFC_IDX_FMT: rdVal = s.fmt;
      `UFC_IDX_RES1: rdVal = s.res1;
      `UFC_IDX_RES2: rdVal = s.res2;
      `UFC_IDX_SUS1: rdVal = s.sus1;
      default: rdVal = s.sus2;
    endcase
    cmpOn = s.feat[1:0] != 2'b00 && !s.feat[`UFC_FEAT_SPEC];
    cmpDbl = s.feat[1:0] == 2'b11;
    offC = s.feat[0] ? s.sus1 : s.sus2;
    onC = s.feat[0] ? s.res1 : s.res2;
    autoOn = s.feat[3:2] != 2'b00;
    autoDbl = s.feat[3:2] == 2'b11;
    toLimit = `UFC_TO_CHARS * charTicks(s.fmt);

    n = s;
    n.pready = 1'b0;
    n.pslverr = 1'b0;
    n.rxPush = 1'b0;
    n.holdRead = 1'b0;
    n.thrWrite = 1'b0;
    n.baudTick = 1'b0;
    srcRead = 1'b0;
    divWr = 1'b0;

    // apb: answer in the first access cycle, effects only at that edge
    if (setup) begin
      n.pready = 1'b1;
      n.pslverr = !mapped;
      n.prdata = mapped ? {24'h000000, rdVal} : 32'h00000000;
    end
    if (acc && mapped && pwrite) begin
      case (idx)
        `UFC_IDX_DATA: begin
          if (dlab) begin
            n.divLow = pwdata[7:0];
            divWr = 1'b1;
          end else begin
            n.thrWrite = 1'b1;
            n.thrData = pwdata[7:0];
            n.thrPend = 1'b0;
          end
        end
        `UFC_IDX_MASK: begin
          if (dlab) begin
            n.divHigh = pwdata[7:0];
            divWr = 1'b1;
          end else begin
            n.mask = pwdata[7:0];
          end
        end
        `UFC_IDX_SRC: n.feat = pwdata[7:0];
        `UFC_IDX_FMT: n.fmt = pwdata[7:0];
        `UFC_IDX_RES1: n.res1 = pwdata[7:0];
        `UFC_IDX_RES2: n.res2 = pwdata[7:0];
        `UFC_IDX_SUS1: n.sus1 = pwdata[7:0];
        default: n.sus2 = pwdata[7:0];
      endcase
    end
    if (acc && mapped && !pwrite) begin
      if (idx == `UFC_IDX_DATA && !dlab)
        n.holdRead = 1'b1;
      if (idx == `UFC_IDX_SRC && !enh)
        srcRead = 1'b1;
    end
    if (srcRead) begin
      n.specialFlag = 1'b0;
      if (srcCode == `UFC_SRC_THR)
        n.thrPend = 1'b0;
    end
    // holding-empty event, or enable raised while already empty; set beats clear
    n.prevThrEmpty = thrEmpty;
    if ((thrEmpty && !s.prevThrEmpty) ||
        (thrEmpty && n.mask[`UFC_MASK_THR] && !s.mask[`UFC_MASK_THR]))
      n.thrPend = 1'b1;

    // baud generator: down-counter reloaded from the divisor, zero divisor stops it
    if (divWr) begin
      n.baudCnt = {n.divHigh, n.divLow};
    end else if ({s.divHigh, s.divLow} != 16'h0000) begin
      if (s.baudCnt <= 16'h0001) begin
        n.baudCnt = {s.divHigh, s.divLow};
        n.baudTick = 1'b1;
      end else begin
        n.baudCnt = s.baudCnt - 16'h0001;
      end
    end

    // receive time-out counts 16x ticks
    if (rxStopMid || n.holdRead) begin
      n.toCnt = 10'h000;
      n.toFlag = 1'b0;
    end else if (rxFifoCount == 6'h00) begin
      n.toCnt = 10'h000;
      n.toFlag = 1'b0;
    end else if (s.baudTick && !s.toFlag) begin
      if (s.toCnt >= toLimit - 10'h001)
        n.toFlag = 1'b1;
      else
        n.toCnt = s.toCnt + 10'h001;
    end

    // the character that broke a held pair goes out a cycle after the held first one
    if (s.deferValid) begin
      n.rxPush = 1'b1;
      n.rxPushData = s.deferChar;
      n.deferValid = 1'b0;
    end
    if (rxCharValid) begin
      if (s.feat[`UFC_FEAT_SPEC]) begin
        // special mode keeps the character and only flags it
        n.rxPush = 1'b1;
        n.rxPushData = rxChar;
        if (chEq(rxChar, s.sus2, s.fmt[1:0]))
          n.specialFlag = 1'b1;
      end else if (cmpOn && !cmpDbl) begin
        if (chEq(rxChar, offC, s.fmt[1:0])) begin
          n.txSuspended = 1'b1;
          if (s.mask[`UFC_MASK_SUSP])
            n.susFlag = 1'b1;
        end else if (chEq(rxChar, onC, s.fmt[1:0])) begin
          n.txSuspended = 1'b0;
          n.susFlag = 1'b0;
        end else begin
          n.rxPush = 1'b1;
          n.rxPushData = rxChar;
        end
      end else if (cmpOn) begin
        case (s.rxSt)
          ufc_pkg::RX_IDLE: begin
            if (chEq(rxChar, s.sus1, s.fmt[1:0])) begin
              n.rxSt = ufc_pkg::RX_HELD;
              n.heldSus = 1'b1;
              n.heldChar = rxChar;
            end else if (chEq(rxChar, s.res1, s.fmt[1:0])) begin
              n.rxSt = ufc_pkg::RX_HELD;
              n.heldSus = 1'b0;
              n.heldChar = rxChar;
            end else begin
              n.rxPush = 1'b1;
              n.rxPushData = rxChar;
            end
          end
          ufc_pkg::RX_HELD: begin
            n.rxSt = ufc_pkg::RX_IDLE;
            if (s.heldSus && chEq(rxChar, s.sus2, s.fmt[1:0])) begin
              n.txSuspended = 1'b1;
              if (s.mask[`UFC_MASK_SUSP])
                n.susFlag = 1'b1;
            end else if (!s.heldSus && chEq(rxChar, s.res2, s.fmt[1:0])) begin
              n.txSuspended = 1'b0;
              n.susFlag = 1'b0;
            end else begin
              n.rxPush = 1'b1;
              n.rxPushData = s.heldChar;
              n.deferValid = 1'b1;
              n.deferChar = rxChar;
            end
          end
          default: n.rxSt = ufc_pkg::RX_IDLE;
        endcase
      end else begin
        n.rxPush = 1'b1;
        n.rxPushData = rxChar;
      end
    end
    if (!cmpOn || !cmpDbl)
      n.rxSt = ufc_pkg::RX_IDLE;
    // the shifter only starts a character while this is high, so a
    // character already in flight always completes
    n.txStartOk = !n.txSuspended;

    // automatic sending of suspend / resume around the trigger level
    case (s.sendSt)
      ufc_pkg::SN_IDLE: begin
        if (autoOn && !s.sentSus && rxFifoCount > rxTrigLevel) begin
          n.sendSt = ufc_pkg::SN_FIRST;
          n.sendSus = 1'b1;
          n.sentSus = 1'b1;
          n.injValid = 1'b1;
          n.injChar = (autoDbl || s.feat[2]) ? s.sus1 : s.sus2;
        end else if (autoOn && s.sentSus && rxFifoCount < rxTrigLevel) begin
          n.sendSt = ufc_pkg::SN_FIRST;
          n.sendSus = 1'b0;
          n.sentSus = 1'b0;
          n.injValid = 1'b1;
          n.injChar = (autoDbl || s.feat[2]) ? s.res1 : s.res2;
        end else if (!autoOn) begin
          n.sentSus = 1'b0;
        end
      end
      ufc_pkg::SN_FIRST: begin
        if (injTaken) begin
          if (autoDbl) begin
            n.sendSt = ufc_pkg::SN_SECOND;
            n.injChar = s.sendSus ? s.sus2 : s.res2;
          end else begin
            n.sendSt = ufc_pkg::SN_IDLE;
            n.injValid = 1'b0;
          end
        end
      end
      ufc_pkg::SN_SECOND: begin
        if (injTaken) begin
          n.sendSt = ufc_pkg::SN_IDLE;
          n.injValid = 1'b0;
        end
      end
      default: begin
        n.sendSt = ufc_pkg::SN_IDLE;
        n.injValid = 1'b0;
      end
    endcase

    n.irq = srcCode != `UFC_SRC_NONE;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s <= '0;
      s.rxSt <= ufc_pkg::RX_IDLE;
      s.sendSt <= ufc_pkg::SN_IDLE;
      s.txStartOk <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign rxPush = s.rxPush;
  assign rxPushData = s.rxPushData;
  assign holdRead = s.holdRead;
  assign thrWrite = s.thrWrite;
  assign thrData = s.thrData;
  assign txStartOk = s.txStartOk;
  assign injValid = s.injValid;
  assign injChar = s.injChar;
  assign baudTick = s.baudTick;
  assign irq = s.irq;

  chk_reset_chars: assert property (@(posedge clock) rst |=>
    s.res1 == 8'h00 && s.res2 == 8'h00 && s.sus1 == 8'h00 && s.sus2 == 8'h00)
    else $error("flow chars not cleared by reset");
  chk_tick_spacing: assert property (@(posedge clock) disable iff (rst)
    (s.baudTick && {s.divHigh, s.divLow} == 16'h0002 && !psel)
    |=> !s.baudTick ##1 s.baudTick)
    else $error("baud tick spacing wrong");
  chk_to_empty: assert property (@(posedge clock) disable iff (rst)
    (rxFifoCount == 6'h00) |=> !s.toFlag)
    else $error("time-out with empty fifo");
  chk_flow_drop: assert property (@(posedge clock) disable iff (rst)
    (rxCharValid && cmpOn && !cmpDbl && !s.deferValid && chEq(rxChar, offC, s.fmt[1:0]))
    |=> !s.rxPush && !s.txStartOk)
    else $error("suspend char stored or tx not halted");
  chk_special_keep: assert property (@(posedge clock) disable iff (rst)
    (rxCharValid && s.feat[`UFC_FEAT_SPEC] && chEq(rxChar, s.sus2, s.fmt[1:0]))
    |=> s.rxPush && s.specialFlag)
    else $error("special char not stored or flagged");
  chk_irq_masked: assert property (@(posedge clock) disable iff (rst)
    (s.mask == 8'h00 && $past(s.mask) == 8'h00) |-> !s.irq)
    else $error("interrupt with all sources disabled");
  chk_divisor_map: assert property (@(posedge clock) disable iff (rst)
    (acc && pwrite && idx == `UFC_IDX_DATA && dlab && paddr[1:0] == 2'b00)
    |=> s.divLow == $past(pwdata[7:0]) && !s.thrWrite)
    else $error("divisor low byte not written");
  chk_thr_raise: assert property (@(posedge clock) disable iff (rst)
    (s.thrPend && s.mask[`UFC_MASK_THR]) |=> s.irq)
    else $error("holding-empty interrupt not raised");
endmodule
`default_nettype wire

// ===== bench/ufc_far_model.sv
/*
  far side model: the channel's transmit shifter taking flow characters.
  assumes the flow block holds injValid and injChar until injTaken.
*/
`timescale 1ns/100ps
`default_nettype none
module ufc_far_model (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rst,
  // flow character handshake
  input  wire logic       injValid,
  input  wire logic [3:0] delay,
  output logic            injTaken
);
  logic [3:0] cnt;
  // delay of two or more keeps idle cycles after a take, so no char is taken twice
  always_ff @(posedge clock) begin
    if (rst || !injValid || injTaken) begin
      cnt      <= 4'h0;
      injTaken <= 1'b0;
    end else begin
      cnt      <= cnt + 4'h1;
      injTaken <= (cnt + 4'h1 >= delay);
    end
  end
endmodule
`default_nettype wire

// ===== bench/tb_ufc_flow_ctrl.sv
/*
  self-checking bench for the flow control, interrupt, time-out and baud block.
  assumes ufc_flow_ctrl and the far side model; apb byte address is index * 4.
*/
`timescale 1ns/100ps
`default_nettype none
`include "ufc_defines.svh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_mismatch++; \
  $display("wrong value at %0t: got %h expected %h", $time, (a), (b)); end end
module tb_ufc_flow_ctrl;
  logic        clock, rst, psel, penable, pwrite, pready, pslverr;
  logic [4:0]  paddr;
  logic [31:0] pwdata, prdata, seed;
  logic        rxCharValid, rxStopMid, fifoEnabled, rxPush, holdRead, thrEmpty;
  logic        injTaken, thrWrite, txStartOk, injValid, baudTick, irq;
  logic        lineStatusErr, modemStatusChg, pinFlowEvent;
  logic [7:0]  rxChar, rxFifoData, rxPushData, thrData, injChar, v, e8a, e8b;
  logic [5:0]  rxFifoCount, rxTrigLevel;
  logic [3:0]  delay;
  logic [15:0] g, d;
  logic [32:0] e33;
  logic [32:0] apbq [$];
  logic [7:0]  rxq [$];
  logic [7:0]  injq [$];
  logic [7:0]  thrq [$];
  logic [7:0]  fc [4];
  int          n_mismatch = 0;
  int          n_tests = 0;

  ufc_flow_ctrl u_ufc_flow_ctrl (.clock, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .rxCharValid, .rxChar, .rxStopMid, .rxFifoCount,
    .rxFifoData, .rxTrigLevel, .fifoEnabled, .rxPush, .rxPushData, .holdRead, .thrEmpty,
    .injTaken, .thrWrite, .thrData, .txStartOk, .injValid, .injChar, .lineStatusErr,
    .modemStatusChg, .pinFlowEvent, .baudTick, .irq);
  ufc_far_model u_ufc_far_model (.clock, .rst, .injValid, .delay, .injTaken);

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic results();
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic done(input string s);
    $display("test %s ended", s);
  endtask

  // request held until the edge that samples pready high
  task automatic apb(input logic w, input logic [4:0] a, input logic [7:0] x,
                     input logic [32:0] e);
    if (!w) apbq.push_back(e);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, x};
    @(posedge clock);
    penable <= 1'b1;
    // no cycle count assumed; only the watchdog ends a stuck wait
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [2:0] i, input logic [7:0] x);
    apb(1'b1, {i, 2'b00}, x, 33'h0);
  endtask

  task automatic rd(input logic [2:0] i, input logic [7:0] x);
    apb(1'b0, {i, 2'b00}, 8'h0, {25'h0, x});
  endtask

  // released data line shows the inverse, never the last character
  task automatic rx(input logic [7:0] c, input logic keep);
    if (keep) rxq.push_back(c);
    @(posedge clock);
    rxCharValid <= 1'b1;
    rxChar <= c;
    @(posedge clock);
    rxCharValid <= 1'b0;
    rxChar <= ~c;
    repeat (3) @(posedge clock);
  endtask

  task automatic stop();
    @(posedge clock);
    rxStopMid <= 1'b1;
    @(posedge clock);
    rxStopMid <= 1'b0;
  endtask

  task automatic gap(output logic [15:0] n);
    int k;
    k = 0;
    while (baudTick !== 1'b1 && k < 400) begin
      @(posedge clock);
      k++;
    end
    n = 16'h0;
    do begin
      @(posedge clock);
      n++;
    end while (baudTick !== 1'b1 && n < 16'd400);
  endtask

  task automatic drain();
    int n;
    n = 0;
    while (injq.size() != 0 && n < 300) begin
      @(posedge clock);
      n++;
    end
  endtask

  // results are matched to the oldest note; an unexpected one meets x and fails
  always @(posedge clock) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      e33 = apbq.size() ? apbq.pop_front() : 33'hx;
      `CHK({pslverr, prdata}, e33)
    end
    if (rxPush === 1'b1) begin
      e8a = rxq.size() ? rxq.pop_front() : 8'hxx;
      `CHK(rxPushData, e8a)
    end
    if (injValid === 1'b1 && injTaken === 1'b1) begin
      e8b = injq.size() ? injq.pop_front() : 8'hxx;
      `CHK(injChar, e8b)
    end
    if (thrWrite === 1'b1) begin
      e8b = thrq.size() ? thrq.pop_front() : 8'hxx;
      `CHK(thrData, e8b)
    end
  end

  initial begin
    #300000;
    n_mismatch++;
    results();
  end

  initial begin
    {psel, penable, pwrite, rxCharValid, rxStopMid, fifoEnabled} = '0;
    {thrEmpty, lineStatusErr, modemStatusChg, pinFlowEvent} = '0;
    paddr = '0;
    pwdata = '0;
    rxChar = 8'hff;
    rxFifoData = 8'h00;
    rxFifoCount = 6'h0;
    rxTrigLevel = 6'd8;
    delay = 4'h2;
    seed = 32'h9360;
    fc = '{8'h11, 8'h91, 8'h13, 8'h93};
    rst = 1'b1;
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    wr(`UFC_IDX_FMT, `UFC_FMT_ENH);
    for (int i = 4; i < 8; i++) rd(3'(i), `UFC_RST_BYTE);
    rd(`UFC_IDX_SRC, 8'h00);
    for (int i = 0; i < 4; i++) wr(3'(i + 4), fc[i]);
    for (int i = 0; i < 4; i++) rd(3'(i + 4), fc[i]);
    apb(1'b0, 5'h02, 8'h0, {1'b1, 32'h0});
    done("registers");
    d = 16'(xs() % 8) + 16'h2;
    wr(`UFC_IDX_FMT, 8'h83);
    wr(`UFC_IDX_DATA, d[7:0]);
    wr(`UFC_IDX_MASK, 8'h00);
    rd(`UFC_IDX_DATA, d[7:0]);
    gap(g);
    `CHK(g, d)
    wr(`UFC_IDX_MASK, 8'h01);
    gap(g);
    `CHK(g, d + 16'h100)
    wr(`UFC_IDX_MASK, 8'h00);
    wr(`UFC_IDX_DATA, 8'h02);
    done("baud");
    wr(`UFC_IDX_FMT, 8'h03);
    {thrEmpty, lineStatusErr, pinFlowEvent} <= 3'b111;
    repeat (3) @(posedge clock);
    `CHK(irq, 1'b0)
    rd(`UFC_IDX_SRC, 8'(`UFC_SRC_NONE));
    wr(`UFC_IDX_MASK, 8'h46);
    repeat (3) @(posedge clock);
    `CHK(irq, 1'b1)
    rd(`UFC_IDX_SRC, 8'(`UFC_SRC_LINE));
    lineStatusErr <= 1'b0;
    repeat (3) @(posedge clock);
    rd(`UFC_IDX_SRC, 8'(`UFC_SRC_THR));
    rd(`UFC_IDX_SRC, 8'(`UFC_SRC_PIN));
    thrq.push_back(8'h5a);
    wr(`UFC_IDX_DATA, 8'h5a);
    wr(`UFC_IDX_MASK, 8'h20);
    pinFlowEvent <= 1'b0;
    done("interrupts");
    wr(`UFC_IDX_FMT, `UFC_FMT_ENH);
    wr(`UFC_IDX_SRC, 8'h01);
    wr(`UFC_IDX_FMT, 8'h03);
    rx(8'h13, 1'b0);
    `CHK(txStartOk, 1'b0)
    `CHK(irq, 1'b1)
    rd(`UFC_IDX_SRC, 8'(`UFC_SRC_SUSP));
    rx(8'h41, 1'b1);
    rx(8'h11, 1'b0);
    `CHK(txStartOk, 1'b1)
    rd(`UFC_IDX_SRC, 8'(`UFC_SRC_NONE));
    wr(`UFC_IDX_FMT, 8'h00);
    rx(8'hf3, 1'b0);
    `CHK(txStartOk, 1'b0)
    rx(8'hf1, 1'b0);
    `CHK(txStartOk, 1'b1)
    done("single");
    wr(`UFC_IDX_FMT, `UFC_FMT_ENH);
    wr(`UFC_IDX_SRC, 8'h03);
    wr(`UFC_IDX_FMT, 8'h03);
    rx(8'h13, 1'b0);
    rxq.push_back(8'h13);
    rx(8'h55, 1'b1);
    `CHK(txStartOk, 1'b1)
    rx(8'h13, 1'b0);
    rx(8'h93, 1'b0);
    `CHK(txStartOk, 1'b0)
    rx(8'h11, 1'b0);
    rx(8'h91, 1'b0);
    `CHK(txStartOk, 1'b1)
    done("double");
    wr(`UFC_IDX_FMT, `UFC_FMT_ENH);
    wr(`UFC_IDX_SRC, 8'h20);
    wr(`UFC_IDX_FMT, 8'h03);
    rx(8'h93, 1'b1);
    rd(`UFC_IDX_SRC, 8'(`UFC_SRC_SUSP));
    rd(`UFC_IDX_SRC, 8'(`UFC_SRC_NONE));
    rx(8'h13, 1'b1);
    done("special");
    foreach (fc[k]) if (k < 2) begin
      wr(`UFC_IDX_FMT, `UFC_FMT_ENH);
      wr(`UFC_IDX_SRC, k ? 8'h0c : 8'h04);
      wr(`UFC_IDX_FMT, 8'h03);
      delay <= 4'(xs() % 4) + 4'h2;
      rxFifoCount <= 6'd7;
      repeat (3) @(posedge clock);
      injq.push_back(8'h13);
      if (k) injq.push_back(8'h93);
      rxFifoCount <= 6'd9;
      drain();
      `CHK(injq.size() == 0, 1'b1)
      injq.push_back(8'h11);
      if (k) injq.push_back(8'h91);
      rxFifoCount <= 6'd7;
      drain();
      `CHK(injq.size() == 0, 1'b1)
    end
    done("autosend");
    rxFifoCount <= 6'd0;
    wr(`UFC_IDX_MASK, 8'h01);
    stop();
    repeat (1400) @(posedge clock);
    rd(`UFC_IDX_SRC, 8'(`UFC_SRC_NONE));
    rxFifoCount <= 6'd1;
    stop();
    repeat (1150) @(posedge clock);
    rd(`UFC_IDX_SRC, 8'(`UFC_SRC_NONE));
    repeat (250) @(posedge clock);
    rd(`UFC_IDX_SRC, 8'(`UFC_SRC_RXTO));
    v = 8'(xs());
    rxFifoData <= v;
    rd(`UFC_IDX_DATA, v);
    rxFifoCount <= 6'd8;
    repeat (3) @(posedge clock);
    rd(`UFC_IDX_SRC, 8'(`UFC_SRC_RXD));
    rxFifoCount <= 6'd1;
    repeat (1150) @(posedge clock);
    rd(`UFC_IDX_SRC, 8'(`UFC_SRC_NONE));
    done("timeout");
    results();
  end
endmodule
`undef CHK
`default_nettype wire
